// >>> sar_adc_conversion_sequencer.v
// sequencer for a 10-bit successive-approximation converter
// assumes control bits come from same-clock register logic; comparator and rc pins are asynchronous
// Behaviour
// R1: result registers have no reset; contents after power-on are unknown.
// R2: software waits the acquisition time after changing channel before starting.
// R3: software configures, optionally enables interrupt, waits, starts, awaits, reads result.
// R4: completion shows as start bit clearing and as the converter interrupt.
// R5: after a conversion, next acquisition is held off at least 2 periods.
// R6: each conversion lasts 12 conversion-clock periods.
// R7: clock select picks 2,4,8,16,32,64 oscillator periods or the rc source.
// R8: software keeps the conversion-clock period at or above 1.6 us.
// R9: port reads return zero on every analog-configured pin.
// R10: conversion runs on the selected channel whatever the pin direction.
// R11: clearing start aborts; result registers keep prior value, never partial bits.
// R12: after abort wait 2 periods, then acquisition restarts automatically.
// R13: software powers on before setting the start bit, never in one write.
// R14: completion loads the justified 10-bit result, unused bits zero.
// R15: while disabled the result registers are plain writable 8-bit storage.
// R16: the sampling switch is open for the whole conversion.
// R17: format 1 right-justifies, format 0 left-justifies, with six zero bits.
// R18: completion loads result, clears start and sets the done flag together.
// R19: reset turns the converter off and aborts any conversion.
// R20: divided periods count whole oscillator periods; change select only while idle.
`timescale 1ns/1ps
`include "sar_adc_defs.vh"

module sar_adc_conversion_sequencer
#(
  parameter PORT_W = 8
)
(
  // clock and reset
  input  wire              clk_sys,
  input  wire              sys_rst,
  input  wire              clk_en,
  // configuration
  input  wire              converter_power_on,
  input  wire [2:0]        conversion_clock_select,
  input  wire [2:0]        channel_select,
  input  wire              result_format_bit,
  // start/status bit access
  input  wire              start_set,
  input  wire              start_clear,
  output wire              start_status,
  // completion flag
  input  wire              done_flag_clear,
  output reg               conversion_done_flag,
  input  wire              conversion_done_int_enable,
  output wire              conversion_int,
  // result register software access
  input  wire              result_high_wr,
  input  wire              result_low_wr,
  input  wire [7:0]        result_wdata,
  output wire [7:0]        result_high_byte,
  output wire [7:0]        result_low_byte,
  // analog front end
  input  wire              comparator_in,
  input  wire              rc_osc_tick,
  output wire              sample_switch_closed,
  output wire              dac_valid,
  output wire [9:0]        dac_code,
  // port read-back
  input  wire [PORT_W-1:0] port_pins,
  input  wire [PORT_W-1:0] pin_analog,
  output reg  [PORT_W-1:0] port_read_data
);

  localparam ST_IDLE = 4'b0001;
  localparam ST_ACQ  = 4'b0010;
  localparam ST_CONV = 4'b0100;
  localparam ST_WAIT = 4'b1000;

  reg  [3:0]           state_q;
  reg  [3:0]           cnt_q;
  reg  [9:0]           sar_q;
  reg  [9:0]           trial_q;
  reg  [7:0]           res_hi_q;
  reg  [7:0]           res_lo_q;
  reg                  cmp_s1_q;
  reg                  cmp_s2_q;
  reg                  rc_s1_q;
  reg                  rc_s2_q;
  reg                  rc_s3_q;
  reg  [PORT_W-1:0]    pin_s1_q;
  reg  [PORT_W-1:0]    pin_s2_q;
  wire                 tick;
  wire                 run;
  wire                 busy;
  wire                 done_now;
  wire [9:0]           sar_next;
  wire [15:0]          justified;

  assign busy     = (state_q == ST_CONV);
  assign run      = busy || (state_q == ST_WAIT);
  // comparator high keeps the trial bit, low drops it
  assign sar_next = cmp_s2_q ? (sar_q | trial_q) : sar_q; // R10
  // power-off in the last period aborts, so no flag and no load
  assign done_now = busy && tick && (cnt_q == `CONV_LAST_BIT) && !start_clear && converter_power_on;
  assign justified = result_format_bit ? {`PAD_ZERO6, sar_next} : {sar_next, `PAD_ZERO6}; // R14 R17

  assign start_status         = busy; // R4
  assign conversion_int       = conversion_done_flag & conversion_done_int_enable; // R4
  assign sample_switch_closed = (state_q == ST_ACQ); // R16
  assign dac_valid            = busy;
  assign dac_code             = sar_q | trial_q;
  assign result_high_byte     = res_hi_q;
  assign result_low_byte      = res_lo_q;

  conv_clock_gen u_clk
  (
    .clk_sys                 (clk_sys),
    .sys_rst                 (sys_rst),
    .clk_en                  (clk_en),
    .run                     (run),
    .conversion_clock_select (conversion_clock_select),
    .rc_tick                 (rc_s2_q & ~rc_s3_q),
    .period_tick             (tick)
  );

  // input synchronisers
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      rc_s1_q  <= 1'b0;
      rc_s2_q  <= 1'b0;
      rc_s3_q  <= 1'b0;
      pin_s1_q <= {PORT_W{1'b0}};
      pin_s2_q <= {PORT_W{1'b0}};
    end
    else if (clk_en)
    begin
      cmp_s1_q <= comparator_in;
      cmp_s2_q <= cmp_s1_q;
      rc_s1_q  <= rc_osc_tick;
      rc_s2_q  <= rc_s1_q;
      rc_s3_q  <= rc_s2_q;
      pin_s1_q <= port_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      port_read_data <= {PORT_W{1'b0}};
    else if (clk_en)
      port_read_data <= pin_s2_q & ~pin_analog; // R9
  end

  // sequence control; channel mux is analog and ignores pin direction
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q              <= ST_IDLE; // R19
      cnt_q                <= 4'h0;
      sar_q                <= 10'h000;
      trial_q              <= 10'h000;
      conversion_done_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (done_now)
        conversion_done_flag <= 1'b1; // R18
      else if (done_flag_clear)
        conversion_done_flag <= 1'b0;
      if (!converter_power_on)
      begin
        state_q <= ST_IDLE; // R19
        cnt_q   <= 4'h0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
            state_q <= ST_ACQ;
          ST_ACQ:
            if (start_set)
            begin
              state_q <= ST_CONV; // R16
              cnt_q   <= `CONV_PERIODS; // R6
              sar_q   <= 10'h000;
              trial_q <= 10'h000;
            end
          ST_CONV:
            if (start_clear)
            begin
              // abort lands mid-period; one extra count keeps two whole periods
              state_q <= ST_WAIT; // R11
              cnt_q   <= `WAIT_PERIODS + `CONV_LAST_BIT; // R12
            end
            else if (tick)
            begin
              cnt_q <= cnt_q - 4'h1;
              if (cnt_q == `CONV_PERIODS)
                trial_q <= {1'b1, 9'h000};
              else if (cnt_q == `CONV_LAST_BIT)
              begin
                state_q <= ST_WAIT; // R5
                cnt_q   <= `WAIT_PERIODS;
              end
              else if (trial_q != 10'h000)
              begin
                sar_q   <= sar_next;
                trial_q <= trial_q >> 1;
              end
            end
          ST_WAIT:
            if (tick)
            begin
              if (cnt_q == `CONV_LAST_BIT)
                state_q <= ST_ACQ; // R12
              cnt_q <= cnt_q - 4'h1;
            end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // result storage, deliberately without reset
  always @(posedge clk_sys)
  begin
    if (clk_en)
    begin
      if (done_now && converter_power_on)
      begin
        res_hi_q <= justified[15:8]; // R18
        res_lo_q <= justified[7:0]; // R1
      end
      else
      begin
        if (result_high_wr)
          res_hi_q <= result_wdata; // R15
        if (result_low_wr)
          res_lo_q <= result_wdata; // R15
      end
    end
  end

endmodule

// >>> sar_adc_defs.vh
// constants for the successive-approximation converter sequencer
// assumes inclusion by bare name from every design file
`ifndef SAR_ADC_DEFS_VH
`define SAR_ADC_DEFS_VH

`define RES_BITS         10
`define CONV_PERIODS     4'hC
`define WAIT_PERIODS     4'h2
`define CONV_LAST_BIT    4'h1
`define CSEL_DIV2        3'h0
`define CSEL_DIV4        3'h4
`define CSEL_DIV8        3'h1
`define CSEL_DIV16       3'h5
`define CSEL_DIV32       3'h2
`define CSEL_DIV64       3'h6
`define CSEL_RC_A        3'h3
`define CSEL_RC_B        3'h7
`define DIV2_LAST        6'h01
`define DIV4_LAST        6'h03
`define DIV8_LAST        6'h07
`define DIV16_LAST       6'h0F
`define DIV32_LAST       6'h1F
`define DIV64_LAST       6'h3F
`define PAD_ZERO6        6'h00

`endif

// >>> conv_clock_gen.v
// conversion-clock period tick generator
// assumes rc_tick is already synchronised to clk_sys
`timescale 1ns/1ps
`include "sar_adc_defs.vh"

module conv_clock_gen
(
  // clock and reset
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       clk_en,
  // control
  input  wire       run,
  input  wire [2:0] conversion_clock_select,
  input  wire       rc_tick,
  // output
  output reg        period_tick
);

  reg  [5:0] div_q;
  reg  [5:0] last;
  wire       use_rc;

  assign use_rc = (conversion_clock_select == `CSEL_RC_A) || (conversion_clock_select == `CSEL_RC_B);

  always @*
  begin
    case (conversion_clock_select)
      `CSEL_DIV2:  last = `DIV2_LAST;
      `CSEL_DIV4:  last = `DIV4_LAST;
      `CSEL_DIV8:  last = `DIV8_LAST;
      `CSEL_DIV16: last = `DIV16_LAST;
      `CSEL_DIV32: last = `DIV32_LAST;
      `CSEL_DIV64: last = `DIV64_LAST;
      default:     last = `DIV2_LAST;
    endcase
  end

  // whole oscillator periods counted per tick
  always @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q       <= 6'h00;
      period_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        div_q       <= 6'h00;
        period_tick <= 1'b0;
      end
      else if (use_rc)
      begin
        div_q       <= 6'h00;
        period_tick <= rc_tick; // R7
      end
      else if (div_q >= last)
      begin
        div_q       <= 6'h00;
        period_tick <= 1'b1; // R20
      end
      else
      begin
        div_q       <= div_q + 6'h01;
        period_tick <= 1'b0;
      end
    end
  end

endmodule

// >>> sar_adc_sva.sv
// port checker for the converter sequencer
// assumes binding onto the sequencer top with its port names
`timescale 1ns/1ps
module sar_adc_sva
#(
  parameter PORT_W = 8
)
(
  // clock and control
  input wire              clk_sys,
  input wire              sys_rst,
  input wire              clk_en,
  input wire              converter_power_on,
  input wire [2:0]        conversion_clock_select,
  input wire              start_set,
  input wire              start_clear,
  // status
  input wire              start_status,
  input wire              conversion_done_flag,
  input wire              conversion_done_int_enable,
  input wire              conversion_int,
  input wire              sample_switch_closed,
  input wire              dac_valid,
  // port read-back
  input wire [PORT_W-1:0] pin_analog,
  input wire [PORT_W-1:0] port_read_data
);
  reg [7:0] len_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // cycles spent converting
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      len_q <= 8'h00;
    else
      len_q <= start_status ? len_q + 8'h01 : 8'h00;
  a_switch_open: assert property (start_status |-> !sample_switch_closed)
    else $error("sampling switch closed while converting");
  a_int_mirror: assert property (conversion_int == (conversion_done_flag && conversion_done_int_enable))
    else $error("interrupt differs from flag and enable");
  a_done_together: assert property ($rose(conversion_done_flag) |-> $fell(start_status))
    else $error("flag set without start bit clearing");
  a_start_taken: assert property (start_set && clk_en && converter_power_on && sample_switch_closed
    && !start_clear |=> start_status)
    else $error("start request not taken");
  a_abort_stops: assert property (start_status && start_clear && clk_en
    |=> !start_status && !$rose(conversion_done_flag))
    else $error("abort did not stop conversion");
  a_hold_off: assert property ($fell(start_status) |-> !sample_switch_closed [*4])
    else $error("acquisition resumed too early");
  a_port_zero: assert property ($stable(pin_analog) |-> (port_read_data & pin_analog) == 0)
    else $error("analog pin read back nonzero");
  a_dac_busy: assert property (dac_valid == start_status)
    else $error("dac valid differs from converting");
  a_conv_len: assert property ($rose(conversion_done_flag) && conversion_clock_select == 3'h0
    |-> len_q >= 8'h14 && len_q <= 8'h1A)
    else $error("conversion length wrong at divide by two");
endmodule

bind sar_adc_conversion_sequencer sar_adc_sva #(.PORT_W(PORT_W)) chk_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .converter_power_on(converter_power_on),
  .conversion_clock_select(conversion_clock_select), .start_set(start_set), .start_clear(start_clear),
  .start_status(start_status), .conversion_done_flag(conversion_done_flag),
  .conversion_done_int_enable(conversion_done_int_enable), .conversion_int(conversion_int),
  .sample_switch_closed(sample_switch_closed), .dac_valid(dac_valid),
  .pin_analog(pin_analog), .port_read_data(port_read_data));

// >>> sar_adc_conversion_sequencer_test.sv
// self-checking bench for the converter sequencer
// assumes design and checker are compiled first
`timescale 1ns/1ps
module sar_adc_conversion_sequencer_test;
  reg         clk_sys, sys_rst, pwr, fmt, s_set, s_clr, f_clr, ie, hw, lw, cmp, rc;
  reg  [2:0]  sel;
  reg  [7:0]  wd, pins, ana;
  reg  [17:0] tab;
  wire        st, flag, irq, sw, dv;
  wire [7:0]  hi, lo, prd;
  wire [9:0]  code;
  integer     fails, tests_run, n, k;

  sar_adc_conversion_sequencer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1),
    .converter_power_on(pwr), .conversion_clock_select(sel), .channel_select(3'h5),
    .result_format_bit(fmt), .start_set(s_set), .start_clear(s_clr), .start_status(st),
    .done_flag_clear(f_clr), .conversion_done_flag(flag), .conversion_done_int_enable(ie),
    .conversion_int(irq), .result_high_wr(hw), .result_low_wr(lw), .result_wdata(wd),
    .result_high_byte(hi), .result_low_byte(lo), .comparator_in(cmp), .rc_osc_tick(rc),
    .sample_switch_closed(sw), .dac_valid(dv), .dac_code(code), .port_pins(pins),
    .pin_analog(ana), .port_read_data(prd));

  task give_verdict;
    begin
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task chk_rng(input integer v, input integer a, input integer b);
    begin
      tests_run = tests_run + 1;
      if (v < a || v > b)
      begin
        fails = fails + 1;
        $display("unexpected at %0t: count %0d", $time, v);
      end
    end
  endtask
  // one-cycle strobe: 0 start, 1 abort, 2 flag clear
  task pulse(input [1:0] w);
    begin
      @(posedge clk_sys);
      {f_clr, s_clr, s_set} <= 3'b001 << w;
      @(posedge clk_sys);
      {f_clr, s_clr, s_set} <= 3'b000;
      #1;
    end
  endtask
  task wait_for(input integer which);
    begin
      n = 0;
      while (((which == 0) ? sw : flag) !== 1'b1 && n < 2000)
      begin
        @(posedge clk_sys);
        #1;
        n = n + 1;
      end
    end
  endtask
  task convert(input [2:0] s, input f, input c, input integer div);
    reg [9:0] r;
    begin
      r = {10{c}};
      @(posedge clk_sys);
      sel <= s;
      fmt <= f;
      cmp <= c;
      pulse(2);
      wait_for(0);
      chk(sw, 1'b1);
      pulse(0);
      wait_for(1);
      chk_rng(n, 11 * div, 13 * div + 8);
      chk(st, 1'b0);
      chk(hi, f ? {6'h00, r[9:8]} : r[9:2]);
      chk(lo, f ? r[7:0] : {r[1:0], 6'h00});
      chk(code[9:2], r[9:2]);
      chk({6'h00, code[1:0]}, {6'h00, r[1:0]});
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    rc = 1'b0;
    forever
    begin
      repeat (6) @(posedge clk_sys);
      rc <= ~rc;
    end
  end
  initial
  begin
    #200000;
    fails = fails + 1;
    give_verdict;
  end
  initial
  begin
    {sys_rst, pwr, ie} = 3'b111;
    {fmt, s_set, s_clr, f_clr, hw, lw, cmp} = 7'h00;
    {sel, wd, pins, ana} = 27'h0;
    tab = {3'h6, 3'h2, 3'h5, 3'h1, 3'h4, 3'h0};
    {fails, tests_run} = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk({st, flag, sw}, 8'h00);
    chk(prd, 8'h00);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (k = 0; k < 6; k = k + 1)
      convert(tab[3 * k +: 3], k % 2, k < 3, 2 << k);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    ie <= 1'b0;
    pulse(2);
    chk({irq, flag}, 8'h00);
    convert(3'h3, 1'b1, 1'b1, 12);
    pulse(2);
    wait_for(0);
    pulse(0);
    repeat (6) @(posedge clk_sys);
    pulse(1);
    chk({st, flag, sw}, 8'h00);
    chk(hi, 8'h03);
    chk(lo, 8'hFF);
    wait_for(0);
    chk(sw, 1'b1);
    @(posedge clk_sys);
    pins <= 8'hFF;
    ana <= 8'h0F;
    repeat (5) @(posedge clk_sys);
    #1;
    chk(prd, 8'hF0);
    @(posedge clk_sys);
    pwr <= 1'b0;
    {hw, wd} <= 9'h1A5;
    @(posedge clk_sys);
    {hw, lw, wd} <= 10'h15A;
    @(posedge clk_sys);
    lw <= 1'b0;
    pulse(0);
    chk(st, 1'b0);
    chk(hi, 8'hA5);
    chk(lo, 8'h5A);
    give_verdict;
  end
endmodule
